// ==== eu_pkg.sv ====
// constants, register map and types of the enhanced serial port
// assumes one 100 MHz cpu clock that also serves as the oscillator clock
package eu_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_DATA = 3'h1;
  localparam logic [2:0] ADDR_STATUS = 3'h2;
  localparam logic [2:0] ADDR_POWER = 3'h3;
  localparam logic [2:0] ADDR_DIV_LO = 3'h4;
  localparam logic [2:0] ADDR_DIV_HI = 3'h5;
  localparam logic [2:0] ADDR_CONFIG = 3'h6;
  // serial_control_reg fields
  localparam int CTL_MODE_HI = 7;
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_MULTI = 5;
  localparam int CTL_RX_EN = 4;
  localparam int CTL_TB8 = 3;
  localparam int CTL_RB8 = 2;
  localparam int CTL_TI = 1;
  localparam int CTL_RI = 0;
  // serial_status_reg fields
  localparam int STA_DBL = 7;
  localparam int STA_BREAK = 3;
  localparam int STA_FRAME = 2;
  localparam int STA_BUSY = 0;
  // power_control_reg fields
  localparam int PWR_DOUBLE = 7;
  localparam int PWR_FE_SEL = 6;
  // configuration fields
  localparam int CFG_USE_BRG = 0;
  localparam int CFG_BRK_RST = 1;
  // reset values
  localparam logic [7:0] CONTROL_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] POWER_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h00;
  localparam logic [15:0] DIVISOR_RST = 16'h0000;
  // timing: every bit is sixteen phases
  localparam logic [3:0] LAST_PHASE = 4'hF;
  localparam logic [3:0] SAMPLE_PHASE = 4'h7;
  localparam logic [3:0] CLOCK_HIGH_PHASE = 4'h8;
  localparam logic [3:0] LAST_SHIFT_BIT = 4'h7;
  localparam logic [3:0] LAST_BIT_8 = 4'h9;
  localparam logic [3:0] LAST_BIT_9 = 4'hA;
  localparam logic [7:0] BREAK_TICKS = 8'hB0;
  typedef enum logic [1:0] {
    EU_MODE_SHIFT = 2'b00,
    EU_MODE_8BIT = 2'b01,
    EU_MODE_9FIX = 2'b10,
    EU_MODE_9VAR = 2'b11
  } eu_mode_t;
  typedef enum logic [1:0] {
    EU_ENG_IDLE = 2'b00,
    EU_ENG_FRAME = 2'b01,
    EU_ENG_SHIFT_OUT = 2'b10,
    EU_ENG_SHIFT_IN = 2'b11
  } eu_eng_t;
  typedef enum logic [1:0] {
    EU_RX_IDLE = 2'b00,
    EU_RX_START = 2'b01,
    EU_RX_BITS = 2'b10
  } eu_rx_t;
endpackage : eu_pkg

// ==== eu_baud_gen.sv ====
// independent baud rate generator: one tick per divisor+1 clocks
// assumes the divisor is steady while a frame is in flight
`timescale 1ns/1ps
module eu_baud_gen #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] divisor,
  output logic tick
);
  logic [WIDTH-1:0] count;

  if (WIDTH < 2) begin : g_chk
    $error("eu_baud_gen: WIDTH below 2");
  end

  always_ff @(posedge clk)
  begin
    if (rst || count >= divisor)
      count <= '0;
    else
      count <= count + 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      tick <= 1'b0;
    else
      tick <= (count >= divisor);
  end
endmodule : eu_baud_gen

// ==== eu_uart.sv ====
// enhanced serial port: four modes, three bit-rate sources, framing
// error, break detect with boot reset, optional transmit double buffer
// assumes rxdIn and the shift pin are asynchronous, t1Overflow is a
// one-cycle pulse on clk
`timescale 1ns/1ps
// What this block does
// - mode 0 shifts eight bits lsb first on rxd, clock on txd, clk/16
// - mode 1 frame: low start, eight data lsb first, high stop
// - mode 1 reception stores the stop bit as received ninth bit
// - modes 2/3 frame: start, eight data, transmit ninth bit, stop
// - modes 2/3 reception keep ninth bit, drop the stop bit
// - mode 2 rate is clk/16 or clk/32 by the doubling bit
// - modes 1/3 take timer 1 overflow or divisor; mode 3 equals 2
// - divisor generator counts oscillator clock by 16-bit preload
// - timer 1 overflow halves again while doubling bit is zero
// - framing error always in status; in control bit 7 if selected
// - eleven low bit times flag a break in the status register
// - break may reset the device into programming mode
// - double buffer takes next byte during send, one stop between
// - double buffer off still queues a byte, flags at frame end, sends live ninth bit
// - double buffer on: transmit flag when buffer frees up
// - double buffer: ninth bit latched with the data byte
// - software picks constant divide, timer 1 or divisor source
// - break reset selects the boot address for fetching
module eu_uart (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic t1Overflow,
  input wire logic rxdIn,
  output logic rxdOut,
  output logic rxdOe_n,
  output logic txd,
  output logic breakResetReq,
  output logic bootAddrSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  logic [7:0] ctl, pwr, cfg, rxBuf, bufData;
  logic [15:0] divisor;
  logic fe, brk, dbl, bufFull, bufNine, brgTick, halfDiv, t1Half;
  logic rxS1, rxS2, rxS3, rxLevel, rxPrev;
  eu_pkg::eu_eng_t eng;
  eu_pkg::eu_rx_t rxState;
  eu_pkg::eu_mode_t mode;
  logic [3:0] txPhase, txIdx, rxPhase, rxIdx;
  logic [10:0] txShift;
  logic [8:0] rxShift;
  logic [7:0] brkCnt;
  logic txLine, tiSet, riSet, feSet, brkSet, sampleTick, engTick;
  logic txLoad, engEnd, rxDone, nine, feSel, wrCtl, wrSta;

  assign mode = eu_pkg::eu_mode_t'({ctl[eu_pkg::CTL_MODE_HI],
                                    ctl[eu_pkg::CTL_MODE_LO]});
  assign nine = mode[1];
  assign feSel = pwr[eu_pkg::PWR_FE_SEL];
  assign wrCtl = wr && addr == eu_pkg::ADDR_CONTROL;
  assign wrSta = wr && addr == eu_pkg::ADDR_STATUS;

  function automatic logic flag_next(input logic set, input logic wrIt,
                                     input logic wbit, input logic cur);
    flag_next = set | (wrIt ? (cur & wbit) : cur);
  endfunction : flag_next

  eu_baud_gen #(.WIDTH(16)) u_brg (
    .clk(clk),
    .rst(rst),
    .divisor(divisor),
    .tick(brgTick)
  );

  // pin input: three flops, a change counts once stages two and three agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxS1 <= 1'b1;
      rxS2 <= 1'b1;
      rxS3 <= 1'b1;
      rxLevel <= 1'b1;
      rxPrev <= 1'b1;
    end
    else
    begin
      rxS1 <= rxdIn;
      rxS2 <= rxS1;
      rxS3 <= rxS2;
      if (rxS2 == rxS3)
        rxLevel <= rxS3;
      rxPrev <= rxLevel;
    end
  end

  // sixteen sample ticks per bit in the framed modes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      halfDiv <= 1'b0;
      t1Half <= 1'b0;
    end
    else
    begin
      halfDiv <= ~halfDiv;
      if (t1Overflow)
        t1Half <= ~t1Half;
    end
  end

  always_comb
  begin
    if (mode == eu_pkg::EU_MODE_9FIX)
      sampleTick = pwr[eu_pkg::PWR_DOUBLE] | halfDiv;
    else if (cfg[eu_pkg::CFG_USE_BRG])
      sampleTick = brgTick;
    else
      sampleTick = t1Overflow &
                   (pwr[eu_pkg::PWR_DOUBLE] | t1Half);
  end
  // mode 0 runs every clock: sixteen phases make clk/16
  assign engTick = (mode == eu_pkg::EU_MODE_SHIFT) ? 1'b1 : sampleTick;

  // register writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ctl <= eu_pkg::CONTROL_RST;
      pwr <= eu_pkg::POWER_RST;
      cfg <= eu_pkg::CONFIG_RST;
      dbl <= eu_pkg::STATUS_RST[eu_pkg::STA_DBL];
      divisor <= eu_pkg::DIVISOR_RST;
    end
    else
    begin
      if (wrCtl)
      begin
        // bit 7 aliases the framing error while the select is set
        if (!feSel)
          ctl[eu_pkg::CTL_MODE_HI] <= wdata[eu_pkg::CTL_MODE_HI];
        ctl[6:3] <= wdata[6:3];
      end
      ctl[eu_pkg::CTL_RI] <= flag_next(riSet, wrCtl,
        wdata[eu_pkg::CTL_RI], ctl[eu_pkg::CTL_RI]);
      ctl[eu_pkg::CTL_TI] <= flag_next(tiSet, wrCtl,
        wdata[eu_pkg::CTL_TI], ctl[eu_pkg::CTL_TI]);
      if (rxDone && !ctl[eu_pkg::CTL_RI])
        ctl[eu_pkg::CTL_RB8] <= nine ? rxShift[8] : rxLevel;
      else if (wrCtl)
        ctl[eu_pkg::CTL_RB8] <= wdata[eu_pkg::CTL_RB8];
      if (wrSta)
        dbl <= wdata[eu_pkg::STA_DBL];
      if (wr && addr == eu_pkg::ADDR_POWER)
        pwr <= {wdata[7:6], 6'h00};
      if (wr && addr == eu_pkg::ADDR_CONFIG)
        cfg <= {6'h00, wdata[1:0]};
      if (wr && addr == eu_pkg::ADDR_DIV_LO)
        divisor[7:0] <= wdata;
      if (wr && addr == eu_pkg::ADDR_DIV_HI)
        divisor[15:8] <= wdata;
    end
  end

  // sticky status flags; a hardware set beats a clear in the same cycle
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fe <= 1'b0;
      brk <= 1'b0;
    end
    else
    begin
      brk <= flag_next(brkSet, wrSta, wdata[eu_pkg::STA_BREAK], brk);
      fe <= flag_next(feSet, wrSta || (wrCtl && feSel),
        wrSta ? wdata[eu_pkg::STA_FRAME] : wdata[eu_pkg::CTL_MODE_HI],
        fe);
    end
  end

  // read data stand one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst)
      rdata <= 8'h00;
    else if (rd)
      unique case (addr)
        eu_pkg::ADDR_CONTROL: rdata <= {feSel ? fe : ctl[7], ctl[6:0]};
        eu_pkg::ADDR_DATA: rdata <= rxBuf;
        eu_pkg::ADDR_STATUS: rdata <= {dbl, 3'h0, brk, fe, 1'b0,
                                       eng != eu_pkg::EU_ENG_IDLE};
        eu_pkg::ADDR_POWER: rdata <= pwr;
        eu_pkg::ADDR_DIV_LO: rdata <= divisor[7:0];
        eu_pkg::ADDR_DIV_HI: rdata <= divisor[15:8];
        eu_pkg::ADDR_CONFIG: rdata <= cfg;
        default: rdata <= 8'h00;
      endcase
  end

  // transmit holding buffer; ninth bit travels with the byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      bufFull <= 1'b0;
      bufData <= 8'h00;
      bufNine <= 1'b0;
    end
    else if (wr && addr == eu_pkg::ADDR_DATA)
    begin
      bufFull <= 1'b1;
      bufData <= wdata;
      bufNine <= ctl[eu_pkg::CTL_TB8];
    end
    else if (txLoad)
      bufFull <= 1'b0;
  end

  // with the buffer on, the next byte starts right after one stop bit
  assign txLoad = eng == eu_pkg::EU_ENG_IDLE && bufFull;
  assign engEnd = eng != eu_pkg::EU_ENG_IDLE && engTick &&
    txPhase == eu_pkg::LAST_PHASE &&
    txIdx == ((eng != eu_pkg::EU_ENG_FRAME) ? eu_pkg::LAST_SHIFT_BIT :
              nine ? eu_pkg::LAST_BIT_9 : eu_pkg::LAST_BIT_8);
  assign tiSet = dbl ? txLoad :
    (engEnd && eng != eu_pkg::EU_ENG_SHIFT_IN);

  // shift engine: framed transmit and both mode 0 directions
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      eng <= eu_pkg::EU_ENG_IDLE;
      txPhase <= 4'h0;
      txIdx <= 4'h0;
      txShift <= 11'h7FF;
      txLine <= 1'b1;
    end
    else
      unique case (eng)
        eu_pkg::EU_ENG_IDLE:
        begin
          txPhase <= 4'h0;
          txIdx <= 4'h0;
          txLine <= 1'b1;
          if (txLoad && mode == eu_pkg::EU_MODE_SHIFT)
          begin
            eng <= eu_pkg::EU_ENG_SHIFT_OUT;
            txShift <= {3'h7, bufData};
          end
          else if (txLoad)
          begin
            eng <= eu_pkg::EU_ENG_FRAME;
            txShift <= {1'b1, nine ? bufNine : 1'b1, bufData, 1'b0};
            txLine <= 1'b0;
          end
          else if (mode == eu_pkg::EU_MODE_SHIFT && ctl[eu_pkg::CTL_RX_EN] &&
                   !ctl[eu_pkg::CTL_RI])
            eng <= eu_pkg::EU_ENG_SHIFT_IN;
        end
        default:
        begin
          if (engTick)
            txPhase <= txPhase + 4'h1;
          if (engEnd)
            eng <= eu_pkg::EU_ENG_IDLE;
          else if (engTick && txPhase == eu_pkg::LAST_PHASE)
          begin
            txIdx <= txIdx + 4'h1;
            txShift <= {1'b1, txShift[10:1]};
            // without the buffer the live ninth bit is sent
            if (eng == eu_pkg::EU_ENG_FRAME && txIdx == 4'h8 && nine && !dbl)
              txLine <= ctl[eu_pkg::CTL_TB8];
            else if (eng == eu_pkg::EU_ENG_FRAME)
              txLine <= txShift[1];
          end
        end
      endcase
  end

  // pins: mode 0 clock is low for the first half of each bit
  assign txd = (eng == eu_pkg::EU_ENG_SHIFT_OUT ||
                eng == eu_pkg::EU_ENG_SHIFT_IN) ?
               txPhase[3] : txLine;
  assign rxdOe_n = eng != eu_pkg::EU_ENG_SHIFT_OUT;
  assign rxdOut = (eng == eu_pkg::EU_ENG_SHIFT_OUT) ? txShift[0] : 1'b1;

  // framed receiver, sampled at phase 7 of 16
  assign rxDone = rxState == eu_pkg::EU_RX_BITS && sampleTick &&
    rxPhase == eu_pkg::SAMPLE_PHASE &&
    rxIdx == (nine ? 4'h9 : 4'h8);
  assign riSet = (rxDone && !ctl[eu_pkg::CTL_RI]) ||
    (engEnd && eng == eu_pkg::EU_ENG_SHIFT_IN);
  assign feSet = rxDone && !rxLevel;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rxState <= eu_pkg::EU_RX_IDLE;
      rxPhase <= 4'h0;
      rxIdx <= 4'h0;
      rxShift <= 9'h000;
      rxBuf <= 8'h00;
    end
    else
    begin
      if (eng == eu_pkg::EU_ENG_SHIFT_IN && txPhase == eu_pkg::LAST_PHASE)
        rxShift <= {rxShift[7:0] == 8'h00 ? 1'b0 : rxShift[8], rxLevel,
                    rxShift[7:1]};
      if (engEnd && eng == eu_pkg::EU_ENG_SHIFT_IN)
        rxBuf <= {rxLevel, rxShift[7:1]};
      unique case (rxState)
        eu_pkg::EU_RX_IDLE:
        begin
          rxPhase <= 4'h0;
          rxIdx <= 4'h0;
          if (mode != eu_pkg::EU_MODE_SHIFT && ctl[eu_pkg::CTL_RX_EN] &&
              rxPrev && !rxLevel)
            rxState <= eu_pkg::EU_RX_START;
        end
        eu_pkg::EU_RX_START:
        begin
          if (sampleTick)
            rxPhase <= rxPhase + 4'h1;
          if (sampleTick && rxPhase == eu_pkg::SAMPLE_PHASE)
            rxState <= rxLevel ? eu_pkg::EU_RX_IDLE :
                       eu_pkg::EU_RX_BITS;
        end
        default:
        begin
          if (sampleTick)
            rxPhase <= rxPhase + 4'h1;
          if (sampleTick && rxPhase == eu_pkg::SAMPLE_PHASE)
          begin
            rxIdx <= rxIdx + 4'h1;
            rxShift <= {rxLevel, rxShift[8:1]};
          end
          if (rxDone)
          begin
            rxState <= eu_pkg::EU_RX_IDLE;
            if (!ctl[eu_pkg::CTL_RI])
              rxBuf <= nine ? rxShift[7:0] : rxShift[8:1];
          end
        end
      endcase
    end
  end

  // break: 176 low sample ticks are eleven bit times
  assign brkSet = mode != eu_pkg::EU_MODE_SHIFT && sampleTick &&
    !rxLevel && brkCnt == eu_pkg::BREAK_TICKS - 8'h01;

  always_ff @(posedge clk)
  begin
    if (rst || rxLevel)
      brkCnt <= 8'h00;
    else if (sampleTick && brkCnt != eu_pkg::BREAK_TICKS)
      brkCnt <= brkCnt + 8'h01;
  end

  // a reset request and the boot-address select leave together
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      breakResetReq <= 1'b0;
      bootAddrSelect <= 1'b0;
    end
    else
    begin
      breakResetReq <= brkSet && cfg[eu_pkg::CFG_BRK_RST];
      bootAddrSelect <= brkSet && cfg[eu_pkg::CFG_BRK_RST];
    end
  end

  frame_start_a: assert property (txLoad && mode != eu_pkg::EU_MODE_SHIFT
    |=> !txd) else $error("start bit not low");
  line_idle_a: assert property (eng == eu_pkg::EU_ENG_IDLE |-> txd)
    else $error("idle line not high");
  shift_clock_a: assert property (eng == eu_pkg::EU_ENG_SHIFT_OUT &&
    txPhase < eu_pkg::CLOCK_HIGH_PHASE |-> !txd && !rxdOe_n)
    else $error("mode 0 clock or drive wrong");
  rx_flag_a: assert property (rxDone && !ctl[eu_pkg::CTL_RI]
    |=> ctl[eu_pkg::CTL_RI] && rxBuf == ($past(nine) ? 8'($past(rxShift)) :
    8'($past(rxShift) >> 1)))
    else $error("receive flag or data missed");
  ninth_bit_a: assert property (rxDone && !ctl[eu_pkg::CTL_RI] &&
    mode == eu_pkg::EU_MODE_8BIT |=> ctl[eu_pkg::CTL_RB8] == $past(rxLevel))
    else $error("stop bit not kept");
  break_reset_a: assert property (brkSet && cfg[eu_pkg::CFG_BRK_RST]
    |=> breakResetReq && bootAddrSelect ##1 !breakResetReq)
    else $error("break reset not pulsed");
  dbl_flag_a: assert property (dbl && txLoad |=> ctl[eu_pkg::CTL_TI])
    else $error("transmit flag late with buffer");
  set_wins_a: assert property (tiSet && wrCtl && !wdata[eu_pkg::CTL_TI]
    |=> ctl[eu_pkg::CTL_TI]) else $error("set lost to clear");
  frame_err_a: assert property (feSet |=> fe && (brk || !$past(brkSet)))
    else $error("framing error not flagged");
endmodule : eu_uart

// ==== eu_remote_model.sv ====
// remote serial device on the txd and rxd pins of the serial port
// assumes the bench sets bitClks and frameBits before each exchange
`timescale 1ns/1ps
module eu_remote_model (
  input wire logic clk,
  input wire logic txd,
  output logic rxdLine
);
  int bitClks = 32;
  int frameBits = 10;
  int gotCount = 0;
  longint cyc = 0;
  longint startAt = 0;
  longint prevStartAt = 0;
  logic [10:0] got = 11'h7FF;
  logic [10:0] prevGot = 11'h7FF;

  // the line rests high between frames
  initial rxdLine = 1'b1;

  always @(posedge clk) cyc <= cyc + 1;

  // bits leave lsb first; the bench supplies start, ninth and stop values
  task automatic send(input logic [10:0] bits, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxdLine <= bits[i];
      repeat (bitClks) @(posedge clk);
    end
    rxdLine <= 1'b1;
  endtask : send

  // a low line held past a whole frame is how a break is made
  task automatic hold_low(input int clks);
    rxdLine <= 1'b0;
    repeat (clks) @(posedge clk);
    rxdLine <= 1'b1;
  endtask : hold_low

  // mode 0 reply: each bit goes out just after the port's clock falls,
  // so it stands through the synchroniser delay to the sampling phase
  task automatic shift_reply(input logic [7:0] bits);
    int i;
    logic was;
    i = 0;
    was = txd;
    for (int k = 0; k < 300 && i < 8; k++)
    begin
      @(posedge clk);
      #1;
      if (was === 1'b1 && txd === 1'b0)
      begin
        rxdLine <= bits[i];
        i++;
      end
      was = txd;
    end
    repeat (24) @(posedge clk);
    rxdLine <= 1'b1;
  endtask : shift_reply

  // samples on the falling clock edge so txd updates never race us
  always
  begin
    @(negedge txd);
    prevStartAt = startAt;
    startAt = cyc;
    prevGot = got;
    repeat (bitClks / 2) @(negedge clk);
    for (int i = 0; i < frameBits; i++)
    begin
      got[i] = txd;
      if (i < frameBits - 1)
        repeat (bitClks) @(negedge clk);
    end
    gotCount++;
  end
endmodule : eu_remote_model

// ==== eu_uart_tb_top.sv ====
// self-checking bench for the enhanced serial port
// assumes a 100 MHz clock and the remote model on the serial pins
`timescale 1ns/1ps
module eu_uart_tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic t1Overflow = 1'b0;
  logic [7:0] rdata;
  logic rxdOut;
  logic rxdOe_n;
  logic txd;
  logic breakResetReq;
  logic bootAddrSelect;
  logic rxdLine;
  logic rxdWire;
  int fails = 0;
  int checksDone = 0;

  always #5 clk = ~clk;
  // overflow every second clock keeps the timer source slow but legal
  always @(posedge clk) t1Overflow <= ~t1Overflow;
  // rxd is two-way: in mode 0 transmit the port drives it
  assign rxdWire = rxdOe_n ? rxdLine : rxdOut;

  eu_uart dut_u (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .t1Overflow(t1Overflow), .rxdIn(rxdWire),
    .rxdOut(rxdOut), .rxdOe_n(rxdOe_n), .txd(txd),
    .breakResetReq(breakResetReq), .bootAddrSelect(bootAddrSelect)
  );
  eu_remote_model remote_u (.clk(clk), .txd(txd), .rxdLine(rxdLine));

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    checksDone++;
    if (seen !== want)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, want);
    end
  endtask : check

  task automatic report_and_stop();
    if (fails == 0 && checksDone > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wr_reg

  task automatic expect_reg(input logic [2:0] a, input logic [7:0] mask,
    input logic [7:0] want);
    logic [7:0] v;
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
    check(v & mask, want);
  endtask : expect_reg

  task automatic wait_frames(input int n);
    int k;
    k = 0;
    while (remote_u.gotCount < n && k < 20000)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 20000)
    begin
      fails++;
      report_and_stop();
    end
  endtask : wait_frames

  task automatic setup(input logic [7:0] pwr, input logic [7:0] cfg,
    input logic [7:0] ctl, input int clks, input int n);
    wr_reg(eu_pkg::ADDR_POWER, pwr);
    wr_reg(eu_pkg::ADDR_CONFIG, cfg);
    wr_reg(eu_pkg::ADDR_CONTROL, ctl);
    remote_u.bitClks = clks;
    remote_u.frameBits = n;
  endtask : setup

  task automatic t_reset();
    for (int i = 0; i < 8; i++)
      expect_reg(3'(i), 8'hFF, 8'h00);
  endtask : t_reset

  task automatic t_mode1_brg();
    int n;
    wr_reg(eu_pkg::ADDR_DIV_LO, 8'h01);
    wr_reg(eu_pkg::ADDR_DIV_HI, 8'h00);
    expect_reg(eu_pkg::ADDR_DIV_LO, 8'hFF, 8'h01);
    setup(8'h00, 8'h01, 8'h50, 32, 10);
    n = remote_u.gotCount;
    wr_reg(eu_pkg::ADDR_DATA, 8'hA5);
    wait_frames(n + 1);
    check(remote_u.got[8:1], 8'hA5);
    check({6'h0, remote_u.got[9], remote_u.got[0]}, 8'h02);
    repeat (40) @(posedge clk);
    expect_reg(eu_pkg::ADDR_CONTROL, 8'h03, 8'h02);
    remote_u.send({2'b11, 8'h3C, 1'b0}, 10);
    repeat (4) @(posedge clk);
    expect_reg(eu_pkg::ADDR_DATA, 8'hFF, 8'h3C);
    expect_reg(eu_pkg::ADDR_CONTROL, 8'h05, 8'h05);
  endtask : t_mode1_brg

  task automatic t_mode3_t1();
    int n;
    // tb8 is set ahead of the data write and left alone
    setup(8'h00, 8'h00, 8'hD8, 64, 11);
    n = remote_u.gotCount;
    wr_reg(eu_pkg::ADDR_DATA, 8'h5A);
    wait_frames(n + 1);
    check(remote_u.got[8:1], 8'h5A);
    check({5'h0, remote_u.got[10:9], remote_u.got[0]}, 8'h06);
    repeat (80) @(posedge clk);
    remote_u.send({2'b10, 8'hC3, 1'b0}, 11);
    repeat (4) @(posedge clk);
    expect_reg(eu_pkg::ADDR_DATA, 8'hFF, 8'hC3);
    expect_reg(eu_pkg::ADDR_CONTROL, 8'h05, 8'h01);
  endtask : t_mode3_t1

  task automatic t_mode2_fe();
    int n;
    setup(8'h80, 8'h00, 8'h90, 16, 11);
    n = remote_u.gotCount;
    wr_reg(eu_pkg::ADDR_DATA, 8'h3C);
    wait_frames(n + 1);
    check(remote_u.got[8:1], 8'h3C);
    repeat (40) @(posedge clk);
    wr_reg(eu_pkg::ADDR_POWER, 8'hC0);
    // stop bit sent low to provoke a framing error
    remote_u.send({2'b01, 8'h81, 1'b0}, 11);
    repeat (4) @(posedge clk);
    expect_reg(eu_pkg::ADDR_DATA, 8'hFF, 8'h81);
    expect_reg(eu_pkg::ADDR_STATUS, 8'h04, 8'h04);
    expect_reg(eu_pkg::ADDR_CONTROL, 8'h85, 8'h85);
    wr_reg(eu_pkg::ADDR_STATUS, 8'h00);
    expect_reg(eu_pkg::ADDR_STATUS, 8'h04, 8'h00);
  endtask : t_mode2_fe

  task automatic t_double();
    int n;
    longint gap;
    // mode 3 on the divisor; tb8 is set ahead of the first data write and cleared before the second
    setup(8'h00, 8'h01, 8'hC8, 32, 11);
    wr_reg(eu_pkg::ADDR_STATUS, 8'h80);
    n = remote_u.gotCount;
    addr <= eu_pkg::ADDR_DATA;
    wdata <= 8'h11;
    wr <= 1'b1;
    @(posedge clk);
    // a flag clear lands on the load edge: the hardware set must win
    addr <= eu_pkg::ADDR_CONTROL;
    wdata <= 8'hC8;
    @(posedge clk);
    wr <= 1'b0;
    expect_reg(eu_pkg::ADDR_CONTROL, 8'h02, 8'h02);
    wr_reg(eu_pkg::ADDR_CONTROL, 8'hC0);
    wr_reg(eu_pkg::ADDR_DATA, 8'h22);
    expect_reg(eu_pkg::ADDR_CONTROL, 8'h02, 8'h00);
    wait_frames(n + 2);
    check(remote_u.prevGot[8:1], 8'h11);
    check(remote_u.got[8:1], 8'h22);
    check({6'h0, remote_u.prevGot[9], remote_u.got[9]}, 8'h02);
    gap = remote_u.startAt - remote_u.prevStartAt;
    check({7'h0, (gap >= 350 && gap <= 356)}, 8'h01);
    repeat (40) @(posedge clk);
    wr_reg(eu_pkg::ADDR_STATUS, 8'h00);
  endtask : t_double

  task automatic t_break();
    int at;
    logic both;
    at = 0;
    both = 1'b0;
    setup(8'h00, 8'h03, 8'h50, 32, 10);
    fork
      remote_u.hold_low(400);
      for (int k = 0; k < 400; k++)
      begin
        @(posedge clk);
        #1;
        if (breakResetReq === 1'b1 && at == 0)
        begin
          at = k + 1;
          both = bootAddrSelect;
        end
      end
    join
    check({7'h0, (at >= 352 && at <= 364)}, 8'h01);
    check({7'h0, both}, 8'h01);
    repeat (40) @(posedge clk);
    expect_reg(eu_pkg::ADDR_STATUS, 8'h08, 8'h08);
    // the system answers the request by resetting the port mid-run
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    expect_reg(eu_pkg::ADDR_STATUS, 8'hFF, 8'h00);
  endtask : t_break

  task automatic t_mode0();
    logic [7:0] v;
    logic oe;
    logic last;
    int bits;
    int first;
    int lastk;
    v = 8'h00;
    oe = 1'b0;
    last = 1'b1;
    bits = 0;
    first = 0;
    lastk = 0;
    // double buffering stays off here
    setup(8'h00, 8'h00, 8'h00, 16, 10);
    wr_reg(eu_pkg::ADDR_DATA, 8'hB4);
    for (int k = 0; k < 200; k++)
    begin
      @(posedge clk);
      #1;
      if (txd === 1'b1 && last === 1'b0 && bits < 8)
      begin
        v[bits] = rxdOut;
        oe = oe | rxdOe_n;
        if (bits == 0)
          first = k;
        lastk = k;
        bits++;
      end
      last = txd;
    end
    check(v, 8'hB4);
    check({7'h0, oe}, 8'h00);
    check(8'(lastk - first), 8'h70);
    // enabling reception with ri clear starts the mode 0 shift-in
    fork
      remote_u.shift_reply(8'h6B);
      wr_reg(eu_pkg::ADDR_CONTROL, 8'h10);
    join
    expect_reg(eu_pkg::ADDR_DATA, 8'hFF, 8'h6B);
    expect_reg(eu_pkg::ADDR_CONTROL, 8'h01, 8'h01);
  endtask : t_mode0

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_mode1_brg();
    t_mode3_t1();
    t_mode2_fe();
    t_double();
    t_break();
    t_mode0();
    report_and_stop();
  end
endmodule : eu_uart_tb_top
